// *** bench/pbg_pad_model.sv ***
// Pad model: resolves each pad from the block, an external driver and the pull-ups
`timescale 1ns/1ps
`default_nettype none
module pbg_pad_model (
  input  wire logic       aclk,      // System clock
  input  wire logic [7:0] pin_o,     // Block drive value
  input  wire logic [7:0] pin_oe,    // Block drive enable
  input  wire logic [7:0] pullup_on, // Weak pull-up active
  input  wire logic [7:0] ext_val,   // External driver value
  input  wire logic [7:0] ext_en,    // External driver enable
  output logic      [7:0] pad        // Resolved pad level
);
  logic [7:0] last_r = 8'h00;
  // Undriven pad without pull-up wanders, so a stale level never passes
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (pin_oe[b])
        pad[b] = pin_o[b];
      else if (ext_en[b])
        pad[b] = ext_val[b];
      else if (pullup_on[b])
        pad[b] = 1'b1;
      else
        pad[b] = ~last_r[b];
    end
  end
  always_ff @(posedge aclk) begin
    last_r <= pad;
  end
endmodule : pbg_pad_model
`default_nettype wire

// *** bench/tb_pbg_top.sv ***
// Self-checking bench for the port B GPIO block
`timescale 1ns/1ps
`default_nettype none
module tb_pbg_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, edge_irq_in, ccp_in, ccp_out, ccp_out_en;
  logic tmr_gate_in, prog_mode, prog_clk_in, prog_dat_in, prog_dat_o, prog_dat_oe, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_i, pin_o, pin_oe, pullup_on, ext_val, ext_en;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0]  analog_en, analog_tap;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;

  pbg_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_on(pullup_on), .analog_en(analog_en),
    .analog_tap(analog_tap), .edge_irq_in(edge_irq_in), .ccp_in(ccp_in), .ccp_out(ccp_out),
    .ccp_out_en(ccp_out_en), .tmr_gate_in(tmr_gate_in), .prog_mode(prog_mode), .prog_clk_in(prog_clk_in),
    .prog_dat_in(prog_dat_in), .prog_dat_o(prog_dat_o), .prog_dat_oe(prog_dat_oe), .irq(irq)
  );

  pbg_pad_model i_pads (
    .aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_val(ext_val), .ext_en(ext_en), .pad(pin_i)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // Hang guard; the whole run needs well under two thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_p, w_p, busy;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    busy = 1'b1;
    while (busy) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ar_p, busy;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    ar_p = 1'b1;
    busy = 1'b1;
    while (busy) begin
      @(posedge aclk);
      if (ar_p && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        ar_p = 1'b0;
      end
      if (s_axi_rvalid) begin
        rd_data = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask : rd

  // Two-flop pin synchroniser plus registered outputs need a few edges
  task automatic settle;
    repeat (6) @(posedge aclk);
    #1;
  endtask : settle

  task automatic t_reset;
    logic [7:0] adr [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [7:0] exp [7] = '{8'hFF, 8'hFF, 8'h00, 8'h3F, 8'h01, 8'h00, 8'h00};
    #1;
    check("pullup_on after reset", pullup_on, 8'h00);
    check("pin_oe after reset", pin_oe, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(adr[i]);
      check("reset value", rd_data, {24'h000000, exp[i]});
    end
    rd(8'h20);
    check("unmapped read resp", rsp, pbg_pkg::RESP_SLVERR);
    wr(8'h20, 8'h00);
    check("unmapped write resp", rsp, pbg_pkg::RESP_SLVERR);
    // Lane 0 strobe low: answered, but nothing lands
    s_axi_wstrb <= 4'hE;
    wr(pbg_pkg::ADDR_CHANGE_EN, 8'hFF);
    s_axi_wstrb <= 4'hF;
    check("strobed-off write resp", rsp, pbg_pkg::RESP_OKAY);
    rd(pbg_pkg::ADDR_CHANGE_EN);
    check("strobed-off write ignored", rd_data, 32'h00000000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_drive;
    wr(pbg_pkg::ADDR_ANALOG_SEL, 8'h00);
    wr(pbg_pkg::ADDR_PIN_VALUE, 8'h5A);
    wr(pbg_pkg::ADDR_DIRECTION, 8'h00);
    repeat (2) @(posedge aclk);
    #1;
    check("pin_oe all out", pin_oe, 8'hFF);
    check("pin_o latch", pin_o, 8'h5A);
    rd(pbg_pkg::ADDR_PIN_VALUE);
    check("pin read", rd_data, 32'h0000005A);
    wr(pbg_pkg::ADDR_DIRECTION, 8'hF0);
    wr(pbg_pkg::ADDR_PULLUP, 8'h3C);
    wr(pbg_pkg::ADDR_CONTROL, 8'h00);
    settle;
    check("pin_oe low nibble", pin_oe, 8'h0F);
    check("pull-ups on inputs only", pullup_on, 8'h30);
    wr(pbg_pkg::ADDR_PULLUP, 8'hC0);
    settle;
    check("per-pin pull-up", pullup_on, 8'hC0);
    wr(pbg_pkg::ADDR_CONTROL, 8'h01);
    settle;
    check("global pull-up off", pullup_on, 8'h00);
    $display("test drive and pull-up done");
  endtask : t_drive

  task automatic t_analog;
    wr(pbg_pkg::ADDR_DIRECTION, 8'hFF);
    ext_en  <= 8'hFF;
    ext_val <= 8'hFF;
    wr(pbg_pkg::ADDR_ANALOG_SEL, 8'hFF);
    rd(pbg_pkg::ADDR_ANALOG_SEL);
    check("analog select upper bits", rd_data, 32'h0000003F);
    settle;
    check("analog_en", analog_en, 6'h3F);
    check("analog_tap", analog_tap, 6'h3F);
    rd(pbg_pkg::ADDR_PIN_VALUE);
    check("analog pins read zero", rd_data, 32'h000000C0);
    wr(pbg_pkg::ADDR_ANALOG_SEL, 8'h00);
    settle;
    rd(pbg_pkg::ADDR_PIN_VALUE);
    check("digital pins read", rd_data, 32'h000000FF);
    $display("test analog done");
  endtask : t_analog

  task automatic t_change;
    ext_val <= 8'h00;
    settle;
    rd(pbg_pkg::ADDR_PIN_VALUE);
    wr(pbg_pkg::ADDR_CHANGE_EN, 8'h02);
    wr(pbg_pkg::ADDR_IRQ_MASK, 8'h01);
    // Earlier scenarios leave edge events behind
    wr(pbg_pkg::ADDR_IRQ_STATUS, 8'h03);
    ext_val <= 8'h01;
    settle;
    rd(pbg_pkg::ADDR_IRQ_STATUS);
    check("disabled pin, edge only", rd_data, 32'h00000002);
    check("irq masked edge", irq, 1'b0);
    wr(pbg_pkg::ADDR_IRQ_STATUS, 8'h02);
    ext_val <= 8'h03;
    settle;
    check("irq on change", irq, 1'b1);
    wr(pbg_pkg::ADDR_IRQ_STATUS, 8'h01);
    settle;
    check("flag held by mismatch", irq, 1'b1);
    rd(pbg_pkg::ADDR_PIN_VALUE);
    wr(pbg_pkg::ADDR_IRQ_STATUS, 8'h01);
    settle;
    check("irq cleared", irq, 1'b0);
    rd(pbg_pkg::ADDR_IRQ_STATUS);
    check("status cleared", rd_data, 32'h00000000);
    ext_val <= 8'h01;
    wr(pbg_pkg::ADDR_IRQ_MASK, 8'h00);
    settle;
    rd(pbg_pkg::ADDR_IRQ_STATUS);
    check("status while masked", rd_data, 32'h00000001);
    check("irq masked", irq, 1'b0);
    wr(pbg_pkg::ADDR_PIN_VALUE, 8'h00);
    wr(pbg_pkg::ADDR_IRQ_STATUS, 8'h03);
    $display("test change done");
  endtask : t_change

  task automatic t_alt;
    ext_val <= 8'h29;
    wr(pbg_pkg::ADDR_CONTROL, 8'h03);
    settle;
    check("edge input", edge_irq_in, 1'b1);
    check("timer gate", tmr_gate_in, 1'b1);
    check("capture input", ccp_in, 1'b1);
    ext_en <= 8'h77;
    ccp_out <= 1'b1;
    ccp_out_en <= 1'b1;
    prog_mode <= 1'b1;
    prog_dat_o <= 1'b1;
    prog_dat_oe <= 1'b1;
    ext_val <= 8'h40;
    wr(pbg_pkg::ADDR_DIRECTION, 8'hF7);
    settle;
    check("compare output", {pin_oe[3], pin_o[3]}, 2'h3);
    check("prog data drive", {pin_oe[7], pin_o[7]}, 2'h3);
    check("prog clock in", {pin_oe[6], prog_clk_in}, 2'h1);
    check("prog data in", prog_dat_in, 1'b1);
    prog_mode <= 1'b0;
    settle;
    check("prog clock idle", {pin_oe[7], prog_clk_in}, 2'h0);
    check("prog data idle", prog_dat_in, 1'b0);
    $display("test alternate functions done");
  endtask : t_alt

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h000000000000;
    s_axi_wstrb = 4'hF;
    {ccp_out, ccp_out_en, prog_mode, prog_dat_o, prog_dat_oe} = 5'h00;
    ext_val = 8'h00;
    ext_en = 8'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_drive;
    t_analog;
    t_change;
    t_alt;
    complete_run;
  end
endmodule : tb_pbg_top
`default_nettype wire

// *** hdl/pbg_pin_mux.sv ***
// Per-pin driver and pull-up control with programming-mode override
`timescale 1ns/1ps
`default_nettype none
module pbg_pin_mux (
  input  wire logic [7:0] latch,       // Output latch
  input  wire logic [7:0] dir,         // Direction, 1 = input
  input  wire logic [7:0] pull_en,     // Per-pin pull-up enable
  input  wire logic       pull_dis_n,  // Global pull-up disable, active high
  input  wire logic       alt_ccp,     // Compare output routed here
  input  wire logic       ccp_out,     // Compare/PWM output value
  input  wire logic       ccp_out_en,  // Compare/PWM output active
  input  wire logic       prog_mode,   // Serial programming active
  input  wire logic       prog_dat_o,  // Programming data out
  input  wire logic       prog_dat_oe, // Programming data drive
  output logic      [7:0] pin_o,       // Next pin output value
  output logic      [7:0] pin_oe,      // Next pin output enable
  output logic      [7:0] pull_on      // Next pull-up state
);
  always_comb begin
    pin_o   = latch;
    pin_oe  = ~dir;                                        // RL2
    if (alt_ccp && ccp_out_en) begin
      pin_o[pbg_pkg::PIN_CCP]  = ccp_out;                  // RL12
    end
    if (prog_mode) begin
      pin_oe[pbg_pkg::PIN_PROG_CLK] = 1'b0;                // RL14
      pin_o[pbg_pkg::PIN_PROG_DAT]  = prog_dat_o;
      pin_oe[pbg_pkg::PIN_PROG_DAT] = prog_dat_oe;
    end
    // Pull-up only on undriven pins with global enable
    pull_on = pull_en & ~pin_oe & {8{~pull_dis_n}};        // RL3 RL4 RL5
  end
endmodule : pbg_pin_mux
`default_nettype wire

// *** hdl/pbg_pkg.sv ***
// Package of offsets, reset values and pin positions for the port B GPIO block
package pbg_pkg;
  localparam logic [7:0] ADDR_PIN_VALUE   = 8'h00;
  localparam logic [7:0] ADDR_DIRECTION   = 8'h04;
  localparam logic [7:0] ADDR_PULLUP      = 8'h08;
  localparam logic [7:0] ADDR_CHANGE_EN   = 8'h0C;
  localparam logic [7:0] ADDR_ANALOG_SEL  = 8'h10;
  localparam logic [7:0] ADDR_CONTROL     = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1C;
  localparam logic [7:0] RST_PIN_VALUE    = 8'h00;
  localparam logic [7:0] RST_DIRECTION    = 8'hFF;
  localparam logic [7:0] RST_PULLUP       = 8'hFF;
  localparam logic [7:0] RST_CHANGE_EN    = 8'h00;
  localparam logic [7:0] RST_ANALOG_SEL   = 8'h3F;
  localparam logic [7:0] ANALOG_SEL_MASK  = 8'h3F;
  localparam logic [2:0] RST_CONTROL      = 3'h1;
  localparam int         CTL_PULLUP_DIS_N = 0;
  localparam int         CTL_ALT_CCP      = 1;
  localparam int         CTL_PROG_MODE    = 2;
  localparam logic [1:0] RST_IRQ          = 2'h0;
  localparam int         IRQ_CHANGE       = 0;
  localparam int         IRQ_EDGE         = 1;
  localparam int         PIN_EDGE_IRQ     = 0;
  localparam int         PIN_CCP          = 3;
  localparam int         PIN_TMR_GATE     = 5;
  localparam int         PIN_PROG_CLK     = 6;
  localparam int         PIN_PROG_DAT     = 7;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;
endpackage : pbg_pkg

// *** hdl/pbg_sync.sv ***
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module pbg_sync (
  input  wire logic       aclk,    // System clock
  input  wire logic       aresetn, // Synchronous reset, active low
  input  wire logic [7:0] d,       // Asynchronous pin levels
  output logic      [7:0] q        // Synchronised levels
);
  logic [7:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 8'h00;
      q      <= 8'h00;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pbg_sync
`default_nettype wire

// *** hdl/pbg_top.sv ***
// Port B GPIO block with AXI4-Lite register slave
// Summary of operation
// [RL1] Pin value read returns pin levels
// [RL2] Direction one tri-states, zero drives latch
// [RL3] Per-pin pull-up enable bit
// [RL4] Global active-low disable gates all pull-ups; here a one in control bit 0 turns them all off
// [RL5] Pull-up off while pin is output
// [RL6] Per-pin change detect enable bit
// [RL7] Analog select disables digital input, pins 5-0
// [RL8] Analog select bits 7-6 read zero
// [RL9] Software sets input direction for analog pins
// [RL10] Pins 0-5 feed converter and sensing
// [RL11] Pin zero feeds edge interrupt
// [RL12] Pin three carries alternate capture/compare
// [RL13] Pin five feeds timer gate
// [RL14] Pins 6,7 serve programming clock, data
// [RL15] Analog pins read zero digitally
// [RL16] Enabled mismatches against last read set flag
// [RL17] Port access ends mismatch before clearing flag
// [RL18] Change during port read still sets flag
// [RL19] Writes reach pins next clock edge; here pins change on the second edge after the write fires
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pbg_top (
  input  wire logic        aclk,          // System clock, 100 MHz
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic [7:0]  pin_i,         // Pad input levels
  output logic      [7:0]  pin_o,         // Pad output values
  output logic      [7:0]  pin_oe,        // Pad output enables
  output logic      [7:0]  pullup_on,     // Weak pull-up controls
  output logic      [5:0]  analog_en,     // Analog path enables, pins 5-0
  output logic      [5:0]  analog_tap,    // Pins 5-0 to converter/sensing
  output logic             edge_irq_in,   // Pin 0 to edge interrupt
  output logic             ccp_in,        // Pin 3 capture input
  input  wire logic        ccp_out,       // Compare/PWM output
  input  wire logic        ccp_out_en,    // Compare/PWM output enable
  output logic             tmr_gate_in,   // Pin 5 to timer gate
  input  wire logic        prog_mode,     // Serial programming active
  output logic             prog_clk_in,   // Pin 6 programming clock
  output logic             prog_dat_in,   // Pin 7 programming data
  input  wire logic        prog_dat_o,    // Programming data out
  input  wire logic        prog_dat_oe,   // Programming data drive
  output logic             irq            // Interrupt, active high
);
  logic [7:0] latch_r, dir_r, pull_r, chg_en_r, ana_r, last_rd_r;
  logic [2:0] ctl_r;
  logic [1:0] sts_r, mask_r;
  logic [7:0] pin_sync, dig_in, mux_o, mux_oe, mux_pull;
  logic       edge_prev_r;
  logic       aw_held_r, w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_fire, rd_fire, port_rd, port_wr;
  logic [7:0] mismatch;
  logic [1:0] events;
  logic       wr_ok, rd_ok;
  logic [7:0] rd_val;
  logic       prog_mode_r;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == pbg_pkg::ADDR_PIN_VALUE) || (a == pbg_pkg::ADDR_DIRECTION) ||
                 (a == pbg_pkg::ADDR_PULLUP) || (a == pbg_pkg::ADDR_CHANGE_EN) ||
                 (a == pbg_pkg::ADDR_ANALOG_SEL) || (a == pbg_pkg::ADDR_CONTROL) ||
                 (a == pbg_pkg::ADDR_IRQ_STATUS) || (a == pbg_pkg::ADDR_IRQ_MASK);
  endfunction : addr_known

  pbg_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pin_i),
    .q       (pin_sync)
  );

  // Digital input buffer off on analog pins
  assign dig_in = pin_sync & ~{2'b00, ana_r[5:0]};                  // RL7 RL15

  pbg_pin_mux u_mux (
    .latch       (latch_r),
    .dir         (dir_r),
    .pull_en     (pull_r),
    .pull_dis_n  (ctl_r[pbg_pkg::CTL_PULLUP_DIS_N]),
    .alt_ccp     (ctl_r[pbg_pkg::CTL_ALT_CCP]),
    .ccp_out     (ccp_out),
    .ccp_out_en  (ccp_out_en),
    .prog_mode   (prog_mode_r),
    .prog_dat_o  (prog_dat_o),
    .prog_dat_oe (prog_dat_oe),
    .pin_o       (mux_o),
    .pin_oe      (mux_oe),
    .pull_on     (mux_pull)
  );

  // Write channel: address and data taken in either order
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign port_rd = rd_fire && (s_axi_araddr == pbg_pkg::ADDR_PIN_VALUE);
  assign port_wr = wr_fire && (aw_addr_r == pbg_pkg::ADDR_PIN_VALUE) && w_strb_r[0];
  assign wr_ok   = addr_known(aw_addr_r);
  assign rd_ok   = addr_known(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pbg_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? pbg_pkg::RESP_OKAY : pbg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_r  <= pbg_pkg::RST_PIN_VALUE;
      dir_r    <= pbg_pkg::RST_DIRECTION;
      pull_r   <= pbg_pkg::RST_PULLUP;
      chg_en_r <= pbg_pkg::RST_CHANGE_EN;
      ana_r    <= pbg_pkg::RST_ANALOG_SEL;
      ctl_r    <= pbg_pkg::RST_CONTROL;
      mask_r   <= pbg_pkg::RST_IRQ;
    end else if (wr_fire && w_strb_r[0]) begin
      case (aw_addr_r)
        pbg_pkg::ADDR_PIN_VALUE:  latch_r  <= w_data_r[7:0];                   // RL19
        pbg_pkg::ADDR_DIRECTION:  dir_r    <= w_data_r[7:0];                   // RL2
        pbg_pkg::ADDR_PULLUP:     pull_r   <= w_data_r[7:0];                   // RL3
        pbg_pkg::ADDR_CHANGE_EN:  chg_en_r <= w_data_r[7:0];                   // RL6
        pbg_pkg::ADDR_ANALOG_SEL: ana_r    <= w_data_r[7:0] & pbg_pkg::ANALOG_SEL_MASK; // RL8
        pbg_pkg::ADDR_CONTROL:    ctl_r    <= w_data_r[2:0];
        pbg_pkg::ADDR_IRQ_MASK:   mask_r   <= w_data_r[1:0];
        default: begin
        end
      endcase
    end
  end

  // Snapshot for change compare; taken on any port access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_rd_r <= 8'h00;
    end else if (port_rd || port_wr) begin
      last_rd_r <= dig_in;                                          // RL17
    end
  end

  assign mismatch = (dig_in ^ last_rd_r) & chg_en_r;               // RL16
  assign events[pbg_pkg::IRQ_CHANGE] = |mismatch;
  assign events[pbg_pkg::IRQ_EDGE]   = dig_in[pbg_pkg::PIN_EDGE_IRQ] && !edge_prev_r;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r       <= pbg_pkg::RST_IRQ;
      edge_prev_r <= 1'b0;
    end else begin
      edge_prev_r <= dig_in[pbg_pkg::PIN_EDGE_IRQ];
      if (wr_fire && w_strb_r[0] && aw_addr_r == pbg_pkg::ADDR_IRQ_STATUS) begin
        sts_r <= (sts_r & ~w_data_r[1:0]) | events;                // RL18
      end else begin
        sts_r <= sts_r | events;                                   // RL16
      end
    end
  end

  always_comb begin
    case (s_axi_araddr)
      pbg_pkg::ADDR_PIN_VALUE:  rd_val = dig_in;                    // RL1 RL15
      pbg_pkg::ADDR_DIRECTION:  rd_val = dir_r;
      pbg_pkg::ADDR_PULLUP:     rd_val = pull_r;
      pbg_pkg::ADDR_CHANGE_EN:  rd_val = chg_en_r;
      pbg_pkg::ADDR_ANALOG_SEL: rd_val = ana_r & pbg_pkg::ANALOG_SEL_MASK; // RL8
      pbg_pkg::ADDR_CONTROL:    rd_val = {5'h00, ctl_r};
      pbg_pkg::ADDR_IRQ_STATUS: rd_val = {6'h00, sts_r};
      pbg_pkg::ADDR_IRQ_MASK:   rd_val = {6'h00, mask_r};
      default:                  rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pbg_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_val};
        s_axi_rresp  <= rd_ok ? pbg_pkg::RESP_OKAY : pbg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Registered pin side; control changes appear at the pins two edges after the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o       <= 8'h00;
      pin_oe      <= 8'h00;
      pullup_on   <= 8'h00;
      prog_mode_r <= 1'b0;
    end else begin
      prog_mode_r <= prog_mode;
      pin_o       <= mux_o;                                         // RL19
      pin_oe      <= mux_oe;                                        // RL2
      pullup_on   <= mux_pull;                                      // RL4 RL5
    end
  end

  // Peripheral taps share the synchronised pin levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_en   <= 6'h00;
      analog_tap  <= 6'h00;
      edge_irq_in <= 1'b0;
      ccp_in      <= 1'b0;
      tmr_gate_in <= 1'b0;
      prog_clk_in <= 1'b0;
      prog_dat_in <= 1'b0;
      irq         <= 1'b0;
    end else begin
      analog_en   <= ana_r[5:0];                                    // RL7 RL10
      analog_tap  <= pin_sync[5:0];                                 // RL10
      edge_irq_in <= dig_in[pbg_pkg::PIN_EDGE_IRQ];                 // RL11
      ccp_in      <= ctl_r[pbg_pkg::CTL_ALT_CCP] & dig_in[pbg_pkg::PIN_CCP]; // RL12
      tmr_gate_in <= dig_in[pbg_pkg::PIN_TMR_GATE];                 // RL13
      prog_clk_in <= prog_mode_r & pin_sync[pbg_pkg::PIN_PROG_CLK]; // RL14
      prog_dat_in <= prog_mode_r & pin_sync[pbg_pkg::PIN_PROG_DAT]; // RL14
      irq         <= |(sts_r & mask_r);
    end
  end

  // Assertions
  property p_pullup_gate;
    @(posedge aclk) disable iff (!aresetn)
      ctl_r[pbg_pkg::CTL_PULLUP_DIS_N] |=> pullup_on == 8'h00;
  endproperty
  a_pullup_gate: assert property (p_pullup_gate) else $error("pull-up on while globally disabled"); // RL4

  property p_pullup_output;
    @(posedge aclk) disable iff (!aresetn) (pullup_on & pin_oe) == 8'h00;
  endproperty
  a_pullup_output: assert property (p_pullup_output) else $error("pull-up on a driven pin"); // RL5

  property p_dir_drive;
    @(posedge aclk) disable iff (!aresetn)
      !prog_mode_r && !$past(prog_mode_r) |=> pin_oe == ~$past(dir_r);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("enable does not follow direction"); // RL2

  property p_analog_hi_zero;
    @(posedge aclk) disable iff (!aresetn) ana_r[7:6] == 2'b00;
  endproperty
  a_analog_hi_zero: assert property (p_analog_hi_zero) else $error("analog bits 7-6 set"); // RL8

  property p_analog_reads_zero;
    @(posedge aclk) disable iff (!aresetn) (dig_in[5:0] & ana_r[5:0]) == 6'h00;
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero) else $error("analog pin reads one"); // RL15

  property p_change_flag;
    @(posedge aclk) disable iff (!aresetn) (|mismatch) |=> sts_r[pbg_pkg::IRQ_CHANGE];
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("mismatch did not set flag"); // RL16

  property p_access_snap;
    @(posedge aclk) disable iff (!aresetn) port_rd |=> last_rd_r == $past(dig_in);
  endproperty
  a_access_snap: assert property (p_access_snap) else $error("port read did not snapshot"); // RL17

  property p_write_latency;
    @(posedge aclk) disable iff (!aresetn)
      port_wr && !ctl_r[pbg_pkg::CTL_ALT_CCP] && !prog_mode_r ##1 !prog_mode_r
        |=> pin_o == $past(w_data_r[7:0], 2);
  endproperty
  a_write_latency: assert property (p_write_latency) else $error("latch write late at pins"); // RL19
endmodule : pbg_top
`default_nettype wire
